// ---- verilog/cie_top.sv ----
/*
  Comparator interrupt-enable block with its event flags, behind an
  AHB-Lite slave. Three views of one enable set, one level interrupt.
  Assumes a single AHB-Lite master, word transfers, and event pulses
  from the comparator core that are synchronous to hclk.
*/
module cie_top
  import cie_pkg::*;
(
  // clock, reset, enable
  input logic hclk,
  input logic hresetn,
  input logic ce,
  // ahb-lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // comparator events, one-cycle pulses
  input logic evt_ready_in,
  input logic evt_down_in,
  input logic evt_up_in,
  input logic any_transit_event_in,
  // interrupt request
  output logic irq
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  cie_state_t st_q;
  cie_state_t st_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] hrdata_q;
  logic [DATA_W-1:0] hrdata_d;
  logic hreadyout_q;
  logic hreadyout_d;
  logic [NUM_EVT-1:0] en_q;
  logic [NUM_EVT-1:0] en_d;
  logic irq_q;
  logic irq_d;
  logic [NUM_EVT-1:0] wdata_bits;
  logic accept;
  logic [NUM_EVT-1:0] evt_wr;
  logic [NUM_EVT-1:0] evt_val;
  logic [NUM_EVT-1:0] evt_flags;

  cie_evt_if #(.N(NUM_EVT)) evt_bus ();

  // ----------------------------------------
  // event flag bank
  // ----------------------------------------
  assign evt_bus.hw_set[BIT_READY] = evt_ready_in;
  assign evt_bus.hw_set[BIT_DOWN] = evt_down_in;
  assign evt_bus.hw_set[BIT_UP] = evt_up_in;
  assign evt_bus.hw_set[BIT_ANY] = any_transit_event_in;
  assign evt_bus.sw_wr = evt_wr;
  assign evt_bus.sw_val = evt_val;
  assign evt_flags = evt_bus.flag;

  cie_event_flags #(.N(NUM_EVT)) u_flags
  (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .evt(evt_bus)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // the set and clear views return the live enables, not what was written
  function automatic logic [DATA_W-1:0] read_word
  (
    input logic [ADDR_W-1:0] a,
    input logic [NUM_EVT-1:0] en,
    input logic [NUM_EVT-1:0] fl
  );
    logic [DATA_W-1:0] r;
    r = '0;
    unique case (a)
      OFS_EN_DIRECT: r[NUM_EVT-1:0] = en;
      OFS_EN_SET: r[NUM_EVT-1:0] = en;
      OFS_EN_CLEAR: r[NUM_EVT-1:0] = en;
      OFS_EVT_READY: r[BIT_EVT_FLAG] = fl[BIT_READY];
      OFS_EVT_DOWN: r[BIT_EVT_FLAG] = fl[BIT_DOWN];
      OFS_EVT_UP: r[BIT_EVT_FLAG] = fl[BIT_UP];
      OFS_EVT_ANY: r[BIT_EVT_FLAG] = fl[BIT_ANY];
      OFS_EVT_STATUS: r[NUM_EVT-1:0] = fl;
      default: r = '0;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // bus and enable next state
  // ----------------------------------------
  assign wdata_bits = hwdata[NUM_EVT-1:0];
  assign accept = hsel & hready & htrans[HTRANS_ACTIVE_BIT];

  always_comb
  begin
    st_d = st_q;
    addr_d = addr_q;
    hrdata_d = hrdata_q;
    hreadyout_d = hreadyout_q;
    en_d = en_q;
    evt_wr = '0;
    evt_val = '0;

    // data phase of an earlier transfer
    unique case (st_q)
      ST_IDLE:
      begin
        st_d = ST_IDLE;
      end
      ST_WRITE:
      begin
        st_d = ST_IDLE;
        // one shared enable set behind all three views
        unique case (addr_q)
          OFS_EN_DIRECT: en_d = wdata_bits;
          OFS_EN_SET: en_d = en_q | wdata_bits;
          OFS_EN_CLEAR: en_d = en_q & ~wdata_bits;
          OFS_EVT_READY:
          begin
            evt_wr[BIT_READY] = 1'b1;
            evt_val[BIT_READY] = hwdata[BIT_EVT_FLAG];
          end
          OFS_EVT_DOWN:
          begin
            evt_wr[BIT_DOWN] = 1'b1;
            evt_val[BIT_DOWN] = hwdata[BIT_EVT_FLAG];
          end
          OFS_EVT_UP:
          begin
            evt_wr[BIT_UP] = 1'b1;
            evt_val[BIT_UP] = hwdata[BIT_EVT_FLAG];
          end
          OFS_EVT_ANY:
          begin
            evt_wr[BIT_ANY] = 1'b1;
            evt_val[BIT_ANY] = hwdata[BIT_EVT_FLAG];
          end
          OFS_EVT_CLEAR:
          begin
            evt_wr = wdata_bits;
          end
          default:
          begin
            // unmapped or read-only: write is dropped, still OKAY
            en_d = en_q;
          end
        endcase
      end
      ST_RWAIT:
      begin
        // one wait state so a write just retired is visible to the read
        hrdata_d = read_word(addr_q, en_q, evt_flags);
        hreadyout_d = 1'b1;
        st_d = ST_RDATA;
      end
      ST_RDATA:
      begin
        st_d = ST_IDLE;
      end
    endcase

    // new address phase; never taken while this slave stalls
    if (accept && st_q != ST_RWAIT)
    begin
      addr_d = haddr[ADDR_W-1:0];
      if (hwrite)
      begin
        st_d = ST_WRITE;
      end
      else
      begin
        st_d = ST_RWAIT;
        hreadyout_d = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // interrupt next state
  // ----------------------------------------
  // registered, so irq trails the flag or enable change by one cycle
  always_comb
  begin
    irq_d = |(evt_flags & en_q);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= ST_IDLE;
      addr_q <= '0;
      hrdata_q <= RDATA_RESET;
      hreadyout_q <= 1'b1;
      en_q <= EN_RESET;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= hreadyout_d;
      en_q <= en_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // hsize is not checked: every access is handled as a whole word
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = HRESP_OKAY;
  assign irq = irq_q;

endmodule

// ---- verilog/cie_pkg.sv ----
/*
  Constants shared by the comparator interrupt-enable block: register offsets,
  field positions, reset values, bus encodings and the controller states.
  Assumes a 32-bit AHB-Lite bus whose low address bits select the register.
*/
package cie_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_EVT = 4;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_EVT_READY = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_EVT_DOWN = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_EVT_UP = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_EVT_ANY = 12'h10C;
  localparam logic [ADDR_W-1:0] OFS_EN_DIRECT = 12'h300;
  localparam logic [ADDR_W-1:0] OFS_EN_SET = 12'h304;
  localparam logic [ADDR_W-1:0] OFS_EN_CLEAR = 12'h308;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 12'h310;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 12'h314;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int BIT_READY = 0;
  localparam int BIT_DOWN = 1;
  localparam int BIT_UP = 2;
  localparam int BIT_ANY = 3;
  localparam int BIT_EVT_FLAG = 0;
  localparam logic [NUM_EVT-1:0] EN_RESET = 4'h0;
  localparam logic [NUM_EVT-1:0] EVT_RESET = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  // ----------------------------------------
  // bus encodings
  // ----------------------------------------
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // ----------------------------------------
  // bus controller states
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_RWAIT = 2'b10,
    ST_RDATA = 2'b11
  } cie_state_t;

endpackage

// ---- verilog/cie_evt_if.sv ----
/*
  Carrier between the bus front end and the event flag bank.
  Assumes both ends sit in the same clock domain.
*/
interface cie_evt_if #(parameter int N = 4);
  logic [N-1:0] hw_set;
  logic [N-1:0] sw_wr;
  logic [N-1:0] sw_val;
  logic [N-1:0] flag;

  modport bank
  (
    input hw_set,
    input sw_wr,
    input sw_val,
    output flag
  );

  modport ctrl
  (
    output hw_set,
    output sw_wr,
    output sw_val,
    input flag
  );
endinterface

// ---- verilog/cie_event_flags.sv ----
/*
  Bank of sticky event flags, one per comparator event.
  Assumes event pulses and software writes are synchronous to clk.
*/
module cie_event_flags
  import cie_pkg::*;
#(
  parameter int N = NUM_EVT
)
(
  // clock and reset
  input logic clk,
  input logic rst_n,
  input logic ce,
  // flag traffic
  cie_evt_if.bank evt
);

  logic [N-1:0] flag_q;
  logic [N-1:0] flag_d;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // hardware set beats a software clear in the same cycle
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      flag_d[i] = evt.hw_set[i] | (evt.sw_wr[i] ? evt.sw_val[i] : flag_q[i]);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= N'(EVT_RESET);
    end
    else if (ce)
    begin
      flag_q <= flag_d;
    end
  end

  assign evt.flag = flag_q;

endmodule

// ---- tb/cie_top_assertions.sv ----
/*
  Checker for cie_top: bus timing, enable readback through a shadow
  of the enables, irq gating. Assumes one master, hready tied to
  hreadyout and ce held high during data phases.
*/
module cie_top_assertions
  import cie_pkg::*;
(
  // clock and reset
  input logic hclk,
  input logic hresetn,
  input logic ce,
  // bus
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic hready,
  input logic [31:0] hrdata,
  input logic hreadyout,
  // interrupt
  input logic irq
);
  logic acc;
  logic wr_q;
  logic rd_q;
  logic [ADDR_W-1:0] a_q;
  logic [NUM_EVT-1:0] en_q;
  logic [NUM_EVT-1:0] en_d;

  assign acc = hsel && hready && htrans[1] && ce;

  // ----------------------------------------
  // shadow of the enables, rebuilt from bus traffic
  // ----------------------------------------
  always_comb
  begin
    en_d = en_q;
    if (wr_q && a_q == OFS_EN_DIRECT)
      en_d = hwdata[NUM_EVT-1:0];
    if (wr_q && a_q == OFS_EN_SET)
      en_d = en_q | hwdata[NUM_EVT-1:0];
    if (wr_q && a_q == OFS_EN_CLEAR)
      en_d = en_q & ~hwdata[NUM_EVT-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q <= '0;
      en_q <= EN_RESET;
    end
    else if (ce)
    begin
      wr_q <= acc && hwrite;
      rd_q <= acc && !hwrite;
      en_q <= en_d;
      if (acc)
        a_q <= haddr[ADDR_W-1:0];
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_view_direct: assert property (rd_q && a_q == OFS_EN_DIRECT |=> hrdata == {28'h0, en_q})
    else $error("direct view readback wrong");
  a_view_set: assert property (rd_q && a_q == OFS_EN_SET |=> hrdata == {28'h0, en_q})
    else $error("set view readback wrong");
  a_view_clear: assert property (rd_q && a_q == OFS_EN_CLEAR |=> hrdata == {28'h0, en_q})
    else $error("clear view readback wrong");
  a_write_nowait: assert property (wr_q |-> hreadyout)
    else $error("write data phase stalled");
  a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_rdata_hold: assert property (!rd_q |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_irq_reset: assert property ($rose(hresetn) |-> !irq [*2])
    else $error("irq high after reset");
  a_irq_masked: assert property (en_q == 4'h0 |=> !irq)
    else $error("irq high with all enables off");

  c_set_write: cover property (acc && hwrite && haddr[ADDR_W-1:0] == OFS_EN_SET);
  c_irq_rise: cover property ($rose(irq));
  c_read_done: cover property (rd_q ##1 hreadyout);
endmodule

bind cie_top cie_top_assertions i_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .irq(irq));

// ---- tb/cie_top_tb.sv ----
/*
  Self-checking bench for cie_top: enable views, event interrupt path,
  reset values. Assumes the single slave's hreadyout feeds hready.
*/
module cie_top_tb
  import cie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic [3:0] evt = 4'h0;
  logic ce = 1'b1;
  logic hreadyout;
  logic hresp;
  logic rsp;
  logic irq;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  // write addr, write data, read addr, expected readback
  logic [31:0] rows [9][4] = '{'{32'h300, 32'hFFFFFFFF, 32'h300, 32'hF}, '{32'h308, 32'h5, 32'h304, 32'hA},
    '{32'h304, 32'h1, 32'h308, 32'hB}, '{32'h304, 32'h0, 32'h300, 32'hB}, '{32'h308, 32'h0, 32'h304, 32'hB},
    '{32'h300, 32'h0, 32'h308, 32'h0}, '{32'h304, 32'h4, 32'h300, 32'h4}, '{32'h302, 32'hF, 32'h300, 32'h4},
    '{32'h350, 32'hF, 32'h350, 32'h0}};

  cie_top i_cie_top (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .evt_ready_in(evt[0]), .evt_down_in(evt[1]), .evt_up_in(evt[2]),
    .any_transit_event_in(evt[3]), .irq(irq));

  initial
  begin
    forever #50 hclk = ~hclk;
  end

  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard: the whole run needs well under 1000 cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // ----------------------------------------
  // single-word bus transfer
  // ----------------------------------------
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    // look before the edge: hreadyout and hrdata change on it
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    rsp = hresp;
    @(posedge hclk);
  endtask

  task irq_is(input string nm, input logic v);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk(nm, {31'h0, v}, {31'h0, irq});
    @(posedge hclk);
  endtask

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      bus(1'b1, rows[i][0], rows[i][1]);
      chk("write response", 32'h0, {31'h0, rsp});
      bus(1'b0, rows[i][2], 32'h0);
      chk("enable view", rows[i][3], rd);
    end
    $display("test views done");
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 32'h300, 32'h0);
      evt <= 4'h1 << i;
      @(posedge hclk);
      evt <= 4'h0;
      irq_is("irq masked", 1'b0);
      bus(1'b1, 32'h304, 32'h1 << i);
      irq_is("irq enabled", 1'b1);
      bus(1'b0, 32'h310, 32'h0);
      chk("event status", 32'h1 << i, rd);
      bus(1'b0, 32'h100 + 32'(4 * i), 32'h0);
      chk("event register", 32'h1, rd);
      bus(1'b1, 32'h308, 32'h1 << i);
      irq_is("irq disabled", 1'b0);
      bus(1'b1, 32'h304, 32'h1 << i);
      bus(1'b1, 32'h314, 32'h1 << i);
      irq_is("irq event cleared", 1'b0);
    end
    $display("test interrupts done");
    // event held high across the edge where the clear lands
    evt <= 4'h1;
    bus(1'b1, 32'h314, 32'h1);
    evt <= 4'h0;
    bus(1'b0, 32'h310, 32'h0);
    chk("set beats clear", 32'h1, rd);
    bus(1'b1, 32'h100, 32'h0);
    bus(1'b0, 32'h310, 32'h0);
    chk("event written 0", 32'h0, rd);
    bus(1'b1, 32'h10C, 32'h1);
    bus(1'b0, 32'h310, 32'h0);
    chk("event written 1", 32'h8, rd);
    bus(1'b1, 32'h314, 32'hF);
    $display("test event flags done");
    bus(1'b1, 32'h300, 32'h5);
    ce <= 1'b0;
    bus(1'b1, 32'h300, 32'hA);
    ce <= 1'b1;
    bus(1'b0, 32'h300, 32'h0);
    chk("frozen by ce", 32'h5, rd);
    $display("test clock enable done");
    bus(1'b1, 32'h300, 32'hF);
    evt <= 4'hF;
    @(posedge hclk);
    evt <= 4'h0;
    irq_is("irq before reset", 1'b1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    irq_is("irq after reset", 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b0, 32'h300 + 32'(4 * i), 32'h0);
      chk("enables after reset", 32'h0, rd);
    end
    bus(1'b0, 32'h310, 32'h0);
    chk("events after reset", 32'h0, rd);
    $display("test reset done");
    complete_run();
  end
endmodule
